// [hdl/lkps_pin_mux.sv]
// Pin sharing logic for the LED matrix commons, rows, straps, keys and serial bus.
//
// Function
// - The serial clock is only ever an input while the serial data pin is both read and driven.
// - While displaying, the selected common is driven low and the others stay high.
// - During power-on reset and key scan, common 0 is driven high as the strap source strobe.
// - During key scan, commons 1 to 3 act as active-high key source strobes.
// - While displaying, each row whose segment is lit is driven high.
// - During power-on reset and key scan, rows 0 to 2 are strap inputs with pull-downs.
// - During key scan, the remaining rows are key data inputs with pull-downs.
// - With interrupt select clear, row 15 behaves as a normal row driver and key input.
// - With interrupt select set, row 15 carries only the interrupt output.
// - With the polarity bit set, the interrupt output is active high.
`timescale 1ns/1ps
`default_nettype none

module lkps_pin_mux
  import lkps_pkg::*;
(
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // Mode requests from the controller core, same clock.
  input  wire logic                 por_active_i,
  input  wire logic                 key_scan_i,
  input  wire logic                 display_i,
  input  wire logic [2:0]           com_sel_i,
  input  wire logic [1:0]           key_src_sel_i,
  input  wire logic [NUM_ROW-1:0]   seg_data_i,
  input  wire logic                 int_select_i,
  input  wire logic                 int_polarity_i,
  input  wire logic                 irq_active_i,
  input  wire logic                 sda_pull_low_i,
  // Serial bus pins.
  input  wire logic                 scl_i,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe_o,
  // LED and key matrix pins.
  output logic [NUM_COM-1:0]        com_o,
  input  wire logic [NUM_ROW-1:0]   row_i,
  output logic [NUM_ROW-1:0]        row_o,
  output logic [NUM_ROW-1:0]        row_oe_o,
  output logic [NUM_ROW-1:0]        row_pd_o,
  // Results back to the controller core.
  output logic                      scl_level_o,
  output logic                      sda_level_o,
  output logic                      scl_rise_o,
  output logic                      scl_fall_o,
  output logic [NUM_STRAP-1:0]      addr_strap_o,
  output logic [NUM_KEY-1:0]        key_data_o,
  output logic [1:0]                mode_o
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // One-hot decode of a common index, shared by display and key strobes.
  function automatic logic [NUM_COM-1:0] lkps_onehot(input logic [2:0] idx);
    logic [NUM_COM-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  // The bus clock is sampled like any other pin, never used as a clock.
  logic               scl_meta_reg;
  logic               scl_sync_reg;
  logic               scl_prev_reg;
  logic               sda_meta_reg;
  logic               sda_sync_reg;
  logic [NUM_ROW-1:0] row_meta_reg;
  logic [NUM_ROW-1:0] row_sync_reg;
  logic               scl_rise_reg;
  logic               scl_rise_next;
  logic               scl_fall_reg;
  logic               scl_fall_next;

  // Edge pulses look only at the second and third stages.
  always_comb begin
    scl_rise_next = scl_sync_reg & ~scl_prev_reg;
    scl_fall_next = ~scl_sync_reg & scl_prev_reg;
  end

  // Two flops per pin keep metastability away from the decode logic.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      row_meta_reg <= '0;
      row_sync_reg <= '0;
      scl_rise_reg <= 1'b0;
      scl_fall_reg <= 1'b0;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      row_meta_reg <= row_i;
      row_sync_reg <= row_meta_reg;
      scl_rise_reg <= scl_rise_next;
      scl_fall_reg <= scl_fall_next;
    end
  end

  // ****************************************************************
  // Serial data driver
  // ****************************************************************

  // Open drain: the pin is only ever pulled low, never driven high.
  logic sda_oe_reg;
  logic sda_oe_next;
  logic sda_out_reg;
  logic sda_out_next;

  always_comb begin
    sda_oe_next  = sda_pull_low_i;
    sda_out_next = 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      sda_oe_reg  <= sda_oe_next;
      sda_out_reg <= sda_out_next;
    end
  end

  // ****************************************************************
  // Mode selection
  // ****************************************************************

  // Power-on reset outranks scanning, which outranks display.
  lkps_mode_t mode_reg;
  lkps_mode_t mode_next;

  always_comb begin
    if (por_active_i) begin
      mode_next = LKPS_POR;
    end else if (key_scan_i) begin
      mode_next = LKPS_SCAN;
    end else if (display_i) begin
      mode_next = LKPS_DISP;
    end else begin
      mode_next = LKPS_BLANK;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      mode_reg <= LKPS_POR;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ****************************************************************
  // Common pins
  // ****************************************************************

  logic [NUM_COM-1:0] com_reg;
  logic [NUM_COM-1:0] com_next;
  logic [NUM_COM-1:0] ksrc_hot;

  // Key strobes use the same decoder, offset to commons 1 to 3.
  always_comb begin
    ksrc_hot = lkps_onehot(3'(key_src_sel_i) + 3'(COM_KSRC_LO));
    com_next = COM_RST;
    unique case (mode_next)
      LKPS_DISP: begin
        com_next = ~lkps_onehot(com_sel_i);
      end
      LKPS_SCAN: begin
        com_next[COM_KSRC_LO +: NUM_KSRC] = ksrc_hot[COM_KSRC_LO +: NUM_KSRC];
        com_next[COM_ADDR_POS]            = 1'b1;
      end
      LKPS_POR: begin
        // Key source commons sit low so no key row is energised at reset.
        com_next[COM_KSRC_LO +: NUM_KSRC] = '0;
        com_next[COM_ADDR_POS]            = 1'b1;
      end
      LKPS_BLANK: begin
        com_next = COM_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      com_reg <= COM_RST;
    end else begin
      com_reg <= com_next;
    end
  end

  // ****************************************************************
  // Row pins
  // ****************************************************************

  logic [NUM_ROW-1:0] row_out_reg;
  logic [NUM_ROW-1:0] row_out_next;
  logic [NUM_ROW-1:0] row_oe_reg;
  logic [NUM_ROW-1:0] row_oe_next;
  logic [NUM_ROW-1:0] row_pd_reg;
  logic [NUM_ROW-1:0] row_pd_next;

  // Rows are released to inputs with pull-downs whenever they are read.
  always_comb begin
    row_out_next = ROW_RST;
    row_oe_next  = ROW_OE_RST;
    row_pd_next  = ROW_PD_RST;
    unique case (mode_next)
      LKPS_DISP: begin
        row_out_next = seg_data_i;
        row_oe_next  = '1;
        row_pd_next  = '0;
      end
      LKPS_SCAN: begin
        row_oe_next = '0;
        row_pd_next = '1;
      end
      LKPS_POR: begin
        // Rows outside the straps are held low so the matrix stays dark.
        row_out_next = '0;
        row_oe_next  = '1;
        row_pd_next  = '0;
        row_oe_next[ROW_STRAP_LO +: NUM_STRAP] = '0;
        row_pd_next[ROW_STRAP_LO +: NUM_STRAP] = '1;
      end
      LKPS_BLANK: begin
        row_out_next = '0;
        row_oe_next  = '1;
        row_pd_next  = '0;
      end
    endcase
    // The interrupt pin overrides every mode once it is selected.
    if (int_select_i) begin
      row_out_next[ROW_IRQ_POS] = int_polarity_i ? irq_active_i : ~irq_active_i;
      row_oe_next[ROW_IRQ_POS]  = 1'b1;
      row_pd_next[ROW_IRQ_POS]  = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      row_out_reg <= ROW_RST;
      row_oe_reg  <= ROW_OE_RST;
      row_pd_reg  <= ROW_PD_RST;
    end else begin
      row_out_reg <= row_out_next;
      row_oe_reg  <= row_oe_next;
      row_pd_reg  <= row_pd_next;
    end
  end

  // ****************************************************************
  // Strap and key capture
  // ****************************************************************

  logic [NUM_STRAP-1:0] strap_reg;
  logic [NUM_STRAP-1:0] strap_next;
  logic [NUM_KEY-1:0]   key_reg;
  logic [NUM_KEY-1:0]   key_next;
  logic                 reading;

  // Capture uses the pin mode already on the pins, but row data lags two sync stages,
  // so the first two captures see levels from before the release; the last value before leaving is held.
  always_comb begin
    reading    = (mode_reg == LKPS_POR) || (mode_reg == LKPS_SCAN);
    strap_next = strap_reg;
    key_next   = key_reg;
    if (reading) begin
      for (int i = 0; i < NUM_STRAP; i++) begin
        strap_next[NUM_STRAP-1-i] = row_sync_reg[ROW_STRAP_LO+i];
      end
    end
    if (mode_reg == LKPS_SCAN) begin
      key_next = row_sync_reg[ROW_KEY_LO +: NUM_KEY];
      if (int_select_i) begin
        key_next[NUM_KEY-1] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_reg <= STRAP_RST;
      key_reg   <= KEY_RST;
    end else begin
      strap_reg <= strap_next;
      key_reg   <= key_next;
    end
  end

  // ****************************************************************
  // Output assignments
  // ****************************************************************

  // Every output is a flop; the input path adds two cycles to the bus levels and three to the edge pulses, straps and keys.
  assign sda_o        = sda_out_reg;
  assign sda_oe_o     = sda_oe_reg;
  assign com_o        = com_reg;
  assign row_o        = row_out_reg;
  assign row_oe_o     = row_oe_reg;
  assign row_pd_o     = row_pd_reg;
  assign scl_level_o  = scl_sync_reg;
  assign sda_level_o  = sda_sync_reg;
  assign scl_rise_o   = scl_rise_reg;
  assign scl_fall_o   = scl_fall_reg;
  assign addr_strap_o = strap_reg;
  assign key_data_o   = key_reg;
  assign mode_o       = mode_reg;

endmodule // lkps_pin_mux

`default_nettype wire

// [hdl/lkps_pkg.sv]
// Shared constants and types of the LED and key scan pin sharing block.
`default_nettype none

package lkps_pkg;

  // ****************************************************************
  // Pin group sizes
  // ****************************************************************
  localparam int NUM_COM   = 8;
  localparam int NUM_ROW   = 16;
  localparam int NUM_STRAP = 3;
  localparam int NUM_KEY   = 13;
  localparam int NUM_KSRC  = 3;

  // ****************************************************************
  // Field positions on the pins
  // ****************************************************************
  localparam int COM_ADDR_POS  = 0;   // Address strobe common.
  localparam int COM_KSRC_LO   = 1;   // First key source common.
  localparam int ROW_STRAP_LO  = 0;   // First strap row, it carries strap bit 2.
  localparam int ROW_KEY_LO    = 3;   // First key data row.
  localparam int ROW_IRQ_POS   = 15;  // Row shared with the interrupt output.

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [NUM_COM-1:0]   COM_RST   = 8'hFF;
  localparam logic [NUM_ROW-1:0]   ROW_RST   = 16'h0000;
  localparam logic [NUM_ROW-1:0]   ROW_OE_RST = 16'h0000;
  localparam logic [NUM_ROW-1:0]   ROW_PD_RST = 16'hFFFF;
  localparam logic [NUM_STRAP-1:0] STRAP_RST = 3'h0;
  localparam logic [NUM_KEY-1:0]   KEY_RST   = 13'h0000;

  // ****************************************************************
  // Pin modes, Gray coded along POR, display, scan, blank
  // ****************************************************************
  typedef enum logic [1:0] {
    LKPS_POR   = 2'h0,
    LKPS_DISP  = 2'h1,
    LKPS_SCAN  = 2'h3,
    LKPS_BLANK = 2'h2
  } lkps_mode_t;

endpackage : lkps_pkg

`default_nettype wire

// [sim/lkps_host_model.sv]
// Behavioural bus host that clocks one frame onto the serial pins.
`timescale 1ns/1ps
`default_nettype none

module lkps_host_model (
  input  wire logic start_i,
  input  wire logic sda_line_i,
  output logic      scl_o,
  output logic      sda_low_o,
  output logic      ack_seen_o
);
  // The bus clock stands high between frames and only toggles inside one.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    ack_seen_o = 1'b0;
  end

  // Start, eight data bits, an acknowledge slot the block must pull low, stop.
  always @(posedge start_i) begin
    sda_low_o = 1'b1;
    #32;
    for (int b = 0; b < 9; b++) begin
      scl_o = 1'b0;
      #16 sda_low_o = (b < 8) ? ~b[0] : 1'b0;
      #16 scl_o = 1'b1;
      #28 if (b == 8) ack_seen_o = ~sda_line_i;
      #4;
    end
    scl_o = 1'b0;
    #16 sda_low_o = 1'b1;
    #16 scl_o = 1'b1;
    #16 sda_low_o = 1'b0;
  end
endmodule // lkps_host_model

`default_nettype wire

// [sim/lkps_pin_mux_props.sv]
// Checker of the port relations of the pin sharing block.
`timescale 1ns/1ps
`default_nettype none

module lkps_pin_mux_props
  import lkps_pkg::*;
(
  input wire logic               sys_clk_i,
  input wire logic               rst_i,
  input wire logic               por_active_i,
  input wire logic               key_scan_i,
  input wire logic               display_i,
  input wire logic [2:0]         com_sel_i,
  input wire logic [1:0]         key_src_sel_i,
  input wire logic [NUM_ROW-1:0] seg_data_i,
  input wire logic               int_select_i,
  input wire logic               int_polarity_i,
  input wire logic               irq_active_i,
  input wire logic               sda_pull_low_i,
  input wire logic               sda_o,
  input wire logic               sda_oe_o,
  input wire logic [NUM_COM-1:0] com_o,
  input wire logic [NUM_ROW-1:0] row_o,
  input wire logic [NUM_ROW-1:0] row_oe_o,
  input wire logic [NUM_ROW-1:0] row_pd_o,
  input wire logic               scl_level_o,
  input wire logic               scl_rise_o
);
  // ****************************************************************
  // Mode decode
  // ****************************************************************
  // Priority is power-on reset, then scan, then display.
  wire disp_w = display_i & ~key_scan_i & ~por_active_i;
  wire scan_w = key_scan_i & ~por_active_i;
  wire cap_w  = key_scan_i | por_active_i;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // The first edge after reset still sees reset outputs, hence the guards.
  chk_sda_low_only:
  assert property (sda_oe_o |-> !sda_o) else $error("SDA driven high");
  chk_sda_pull_follow:
  assert property (!$past(rst_i) |-> sda_oe_o == $past(sda_pull_low_i))
    else $error("SDA enable wrong");
  chk_scl_rise_pulse:
  assert property ($rose(scl_level_o) |=> scl_rise_o ##1 !scl_rise_o)
    else $error("SCL rise pulse wrong");
  chk_disp_com_low:
  assert property (!$past(rst_i) && $past(disp_w) |-> com_o == ~(8'h01 << $past(com_sel_i)))
    else $error("Display common wrong");
  chk_addr_strobe_high:
  assert property (!$past(rst_i) && $past(cap_w) |-> com_o[0]) else $error("Strobe low");
  chk_key_source_high:
  assert property (!$past(rst_i) && $past(scan_w && key_src_sel_i != 2'h3)
    |-> com_o[3:1] == (3'h1 << $past(key_src_sel_i))) else $error("Key source wrong");
  chk_disp_rows_high:
  assert property (!$past(rst_i) && $past(disp_w)
    |-> row_o[14:0] == $past(seg_data_i[14:0]) && row_oe_o[14:0] == 15'h7FFF)
    else $error("Display rows wrong");
  chk_strap_pulldown:
  assert property (!$past(rst_i) && $past(cap_w)
    |-> row_oe_o[2:0] == 3'h0 && row_pd_o[2:0] == 3'h7) else $error("Strap rows wrong");
  chk_key_pulldown:
  assert property (!$past(rst_i) && $past(scan_w && !int_select_i)
    |-> row_oe_o[15:3] == 13'h0000 && row_pd_o[15:3] == 13'h1FFF) else $error("Key rows wrong");
  chk_row15_normal:
  assert property (!$past(rst_i) && $past(disp_w && !int_select_i)
    |-> row_oe_o[15] && row_o[15] == $past(seg_data_i[15])) else $error("Row 15 wrong");
  chk_irq_pin_level:
  assert property (!$past(rst_i) && $past(int_select_i) |-> row_oe_o[15] && !row_pd_o[15]
    && row_o[15] == !$past(irq_active_i ^ int_polarity_i)) else $error("Interrupt pin wrong");

  cover property (disp_w ##1 com_o != 8'hFF);
  cover property (scan_w ##1 com_o[1]);
  cover property (int_select_i && irq_active_i);
endmodule // lkps_pin_mux_props

bind lkps_pin_mux lkps_pin_mux_props u_props (.*);

`default_nettype wire

// [sim/test_lkps_pin_mux.sv]
// Self-checking bench of the pin sharing block.
`timescale 1ns/1ps
`default_nettype none

module test_lkps_pin_mux;
  import lkps_pkg::*;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, por_active_i = 1'b0, key_scan_i = 1'b0;
  logic display_i = 1'b0, int_select_i = 1'b0, int_polarity_i = 1'b0, irq_active_i = 1'b0;
  logic sda_pull_low_i = 1'b0, host_go = 1'b0, sda_o, sda_oe_o, host_low, ack_seen;
  logic scl_i, scl_level_o, sda_level_o, scl_rise_o, scl_fall_o;
  logic [2:0] com_sel_i = 3'h0, addr_strap_o;
  logic [1:0] key_src_sel_i = 2'h0, mode_o;
  logic [7:0] com_o;
  logic [15:0] seg_data_i = 16'h0000, keys = 16'h0000, row_i, row_o, row_oe_o, row_pd_o;
  logic [12:0] key_data_o;
  int err_total = 0, samples_checked = 0, cycles = 0;

  // ****************************************************************
  // Pins and partner
  // ****************************************************************
  // SDA has a pull-up; undriven rows without pull-down show the inverse level.
  wire sda_line = ~(host_low | sda_oe_o);
  assign row_i = (row_oe_o & row_o) | (~row_oe_o & (keys | (~row_pd_o & ~row_o)));
  always #4 sys_clk_i = ~sys_clk_i;

  lkps_host_model host (.start_i(host_go), .sda_line_i(sda_line), .scl_o(scl_i),
    .sda_low_o(host_low), .ack_seen_o(ack_seen));
  lkps_pin_mux dut (.*, .sda_i(sda_line));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_display();
    display_i = 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(negedge sys_clk_i) com_sel_i = c[2:0];
      seg_data_i = 16'h8001 | (16'h0100 << c);
      @(negedge sys_clk_i);
      // The cast keeps the inversion at eight bits, as wide as the commons.
      check(com_o, 8'(~(8'h01 << c)));
      check(mode_o, LKPS_DISP);
      check(row_o, 16'h8001 | (16'h0100 << c));
      check(row_oe_o, 16'hFFFF);
    end
  endtask

  task automatic t_scan();
    keys = 16'hB5AE;
    key_scan_i = 1'b1;
    for (int s = 0; s < 3; s++) begin
      @(negedge sys_clk_i) key_src_sel_i = s[1:0];
      repeat (4) @(negedge sys_clk_i);
      check(com_o, 8'hF1 | (8'h02 << s));
      check(mode_o, LKPS_SCAN);
      check(row_pd_o, 16'hFFFF);
      check(key_data_o, 13'h16B5);
      check(addr_strap_o, 3'h3);
    end
  endtask

  task automatic t_por();
    keys = 16'h0001;
    @(negedge sys_clk_i) por_active_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    check(com_o, 8'hF1);
    check(mode_o, LKPS_POR);
    check(row_oe_o, 16'hFFF8);
    check(addr_strap_o, 3'h4);
    check(key_data_o, 13'h16B5);
    @(negedge sys_clk_i) por_active_i = 1'b0;
  endtask

  task automatic t_irq();
    keys = 16'hB5AE;
    int_select_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge sys_clk_i) {int_polarity_i, irq_active_i} = i[1:0];
      repeat (4) @(negedge sys_clk_i);
      // One-bit cast, so the inversion is not widened to the check's width.
      check(row_o[15], 1'(i[1] ? i[0] : ~i[0]));
      check(row_oe_o[15], 1'b1);
      check(key_data_o[12], 1'b0);
    end
  endtask

  // Mid-run reset, then release into blank mode with every request low.
  task automatic t_reset();
    @(negedge sys_clk_i) rst_i = 1'b1;
    {key_scan_i, display_i, int_select_i} = 3'h0;
    repeat (2) @(negedge sys_clk_i);
    check(com_o, 8'hFF);
    check(row_oe_o, 16'h0000);
    check(row_pd_o, 16'hFFFF);
    check(mode_o, LKPS_POR);
    check(key_data_o, 13'h0000);
    check(addr_strap_o, 3'h0);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    check(mode_o, LKPS_BLANK);
    check(com_o, 8'hFF);
    check(row_oe_o, 16'hFFFF);
    check(row_o, 16'h0000);
  endtask

  task automatic t_serial();
    int rises = 0, falls = 0;
    @(negedge sys_clk_i) host_go = 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(negedge sys_clk_i);
      rises += scl_rise_o;
      falls += scl_fall_o;
      sda_pull_low_i = (falls == 9);
    end
    check(rises[15:0], 16'h000A);
    check(falls[15:0], 16'h000A);
    check(ack_seen, 1'b1);
    check(sda_level_o, 1'b1);
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles.
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(negedge sys_clk_i);
    check(com_o, 8'hFF);
    rst_i = 1'b0;
    t_display();
    t_scan();
    t_por();
    t_irq();
    t_reset();
    t_serial();
    complete_run();
  end
endmodule // test_lkps_pin_mux

`default_nettype wire
